// ==== rtl/eeprom_map.svh ====
// constants of the serial eeprom command engine: opcodes, status bit
// positions, array geometry, protect boundaries and timing counts.
// assumes it is included by bare name from the design files.
`ifndef EEPROM_MAP_SVH
`define EEPROM_MAP_SVH

// ----------------------------------------------------------------------
// instruction codes
// ----------------------------------------------------------------------
`define OPC_SET_WE      8'h06
`define OPC_CLR_WE      8'h04
`define OPC_SR_RD       8'h05
`define OPC_SR_WR       8'h01
`define OPC_READ        8'h03
`define OPC_WRITE       8'h02

// ----------------------------------------------------------------------
// status register layout and reset value
// ----------------------------------------------------------------------
`define SR_BUSY         0
`define SR_WEL          1
`define SR_BP_LO        2
`define SR_BP_HI        3
`define SR_LOCK         4
`define SR_IDSEL        6
`define SR_PEN          7
`define SR_RESET        8'h00
`define BP_QTR          2'b01
`define BP_HALF         2'b10
`define BP_ALL          2'b11

// ----------------------------------------------------------------------
// geometry and protect boundaries
// ----------------------------------------------------------------------
`define ARR_BYTES       32768
`define PAGE_BYTES      64
`define ID_BYTES        32
`define QTR_LARGE       15'h6000
`define QTR_SMALL       15'h3000
`define HALF_START      15'h2000
`define BIT_LAST        3'h7

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_MHZ         20
`define WRITE_CYCLE_NS  5000000
`define TMR_W           27

`endif

// ==== rtl/eeprom_pkg.sv ====
// types shared by the serial eeprom command engine.
// assumes nothing of its surroundings.
package eeprom_pkg;

  // serial frame phase, link side
  typedef enum logic [2:0] {
    PH_OPCODE, PH_ADDR1, PH_ADDR2, PH_WDATA, PH_SDATA, PH_READ, PH_STAT,
    PH_IDLE
  } phase_t;

  // what the finished frame asks for
  typedef enum logic [2:0] {
    FK_NONE, FK_SET_WE, FK_CLR_WE, FK_SR_WR, FK_WRITE, FK_READ
  } frame_kind_t;

  // internal programming sequencer
  typedef enum logic {WS_IDLE, WS_PROG} wstate_t;

endpackage

// ==== rtl/spi_eeprom_command_engine.sv ====
// serial eeprom slave: spi modes 0 and 3, command decode, page load,
// self-timed write cycle, status register, id page, hold.
// assumes sck idles while cs_n is high and cs_n stays high >= 4 clk.
//
// Summary of operation
// - write enable latch is clear after reset; all writes refused
// - array and status writes need the write enable latch set
// - array writes into the block-protected region are discarded
// - set-write-enable acts only if cs rises at a byte boundary after the opcode
// - clear-write-enable instruction clears the write enable latch
// - write: opcode, 16 address bits, data; upper address bits ignored
// - programming starts only at cs rise ending a valid write
// - during programming all but status read are ignored
// - busy status bit is 1 while programming, else 0
// - page load up to 64 bytes, only low address bits step
// - load pointer wraps to page start past the last byte
// - write enable latch clears when a write cycle completes
// - id page write uses page sequence, five low address bits
// - id write refused if full protect, locked, or in region
// - status write changes only bits 2, 3, 4, 6 and 7
// - protect pin low with pin enable set blocks status writes
// - protect pin falling during selection with pin enable set aborts a status write
// - read streams bytes from address, wrapping top to bottom
// - status read returns full status anytime, even while busy
// - id select set: read returns id bytes, five-bit address steps
// - hold low pauses: serial out floats, serial in ignored
// - unknown opcodes are ignored, serial out stays floating
// - six opcodes 06, 04, 05, 01, 03, 02 are decoded
// - id select clears itself after a read or write completes
// - status write setting id select and lock together changes neither
// - protect codes: none, top quarter, from 2000h up (top half only at small density), whole array
`timescale 1ns/1ps
`include "eeprom_map.svh"

module spi_eeprom_command_engine #(
  parameter int unsigned WRITE_CYCLE_CLKS =
    (`WRITE_CYCLE_NS * `CLK_MHZ) / 1000,
  parameter bit LARGE_DENSITY = 1'b1
) (
  input  wire logic       clk,     // system clock, 20 mhz
  input  wire logic       rst_n,   // power-on reset, async
  input  wire logic       sck,     // serial clock from host
  input  wire logic       cs_n,    // chip select
  input  wire logic       si,      // serial data in
  input  wire logic       wp_n,    // write protect pin
  input  wire logic       hold_n,  // pause input
  output logic            so,      // serial data out
  output logic            so_oe,   // serial out enable
  output logic [7:0]      status   // status register image
);

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  // clear address bits beyond the density
  function automatic logic [14:0] mask_addr(input logic [14:0] a);
    mask_addr = LARGE_DENSITY ? a : {1'b0, a[13:0]};
  endfunction

  // true when an address falls in the block-protected region
  function automatic logic prot_hit(input logic [14:0] a,
                                    input logic [1:0]  bp);
    logic [14:0] qtr;
    qtr = LARGE_DENSITY ? `QTR_LARGE : `QTR_SMALL;
    case (bp)
      `BP_QTR:  prot_hit = (a >= qtr);
      `BP_HALF: prot_hit = (a >= `HALF_START);
      `BP_ALL:  prot_hit = 1'b1;
      default:  prot_hit = 1'b0;
    endcase
  endfunction

  // next page load slot: only the low bits step
  function automatic logic [5:0] next_ptr(input logic [5:0] p,
                                          input logic       id);
    next_ptr = id ? {1'b0, 5'(p[4:0] + 5'h01)} : 6'(p + 6'h01);
  endfunction

  // --------------------------------------------------------------------
  // storage
  // --------------------------------------------------------------------
  logic [7:0] mem_q  [0:`ARR_BYTES-1];
  logic [7:0] id_q   [0:`ID_BYTES-1];
  logic [7:0] pbuf_q [0:`PAGE_BYTES-1];

  // --------------------------------------------------------------------
  // link side: frame shifting and decode
  // --------------------------------------------------------------------
  logic                  frame_rst_n;
  logic                  oe_rst_n;
  eeprom_pkg::phase_t    phase_q;
  logic [2:0]            bit_cnt_q;
  logic [7:0]            sh_q;
  logic                  is_rd_q;
  logic [7:0]            sr_s1_q;
  logic [7:0]            sr_s2_q;
  eeprom_pkg::frame_kind_t kind_q;
  logic                  exact_q;
  logic [7:0]            sr_byte_q;
  logic [14:0]           addr_q;
  logic [5:0]            ptr_q;
  logic [`PAGE_BYTES-1:0] pmask_q;
  logic [7:0]            rx_byte;
  logic                  byte_done;
  logic                  idsel_l;
  logic                  busy_l;
  logic [7:0]            rd_byte;
  logic [7:0]            osh_q;
  logic [7:0]            status_q;
  logic                  so_q;
  logic                  so_oe_q;

  // deselect clears the frame; hold also drops the output enable
  assign frame_rst_n = rst_n & ~cs_n;
  assign oe_rst_n    = frame_rst_n & hold_n;
  assign rx_byte     = {sh_q[6:0], si};
  assign byte_done   = hold_n && (bit_cnt_q == `BIT_LAST);
  assign idsel_l     = sr_s2_q[`SR_IDSEL];
  assign busy_l      = sr_s2_q[`SR_BUSY];

  // status image brought onto the serial clock
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      sr_s1_q <= `SR_RESET;
      sr_s2_q <= `SR_RESET;
    end else begin
      sr_s1_q <= status_q;
      sr_s2_q <= sr_s1_q;
    end
  end

  // bit counter, shifter and frame phase; si sampled on rising sck
  always_ff @(posedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      phase_q   <= eeprom_pkg::PH_OPCODE;
      bit_cnt_q <= 3'h0;
      sh_q      <= 8'h00;
      is_rd_q   <= 1'b0;
    end else if (hold_n) begin
      bit_cnt_q <= 3'(bit_cnt_q + 3'h1);
      sh_q      <= rx_byte;
      if (bit_cnt_q == `BIT_LAST) begin
        case (phase_q)
          eeprom_pkg::PH_OPCODE: begin
            if (rx_byte == `OPC_SR_RD) begin
              phase_q <= eeprom_pkg::PH_STAT;
            end else if (busy_l) begin
              phase_q <= eeprom_pkg::PH_IDLE;
            end else if (rx_byte == `OPC_SR_WR) begin
              phase_q <= eeprom_pkg::PH_SDATA;
            end else if (rx_byte == `OPC_READ) begin
              phase_q <= eeprom_pkg::PH_ADDR1;
              is_rd_q <= 1'b1;
            end else if (rx_byte == `OPC_WRITE) begin
              phase_q <= eeprom_pkg::PH_ADDR1;
              is_rd_q <= 1'b0;
            end else begin
              phase_q <= eeprom_pkg::PH_IDLE;
            end
          end
          eeprom_pkg::PH_ADDR1: phase_q <= eeprom_pkg::PH_ADDR2;
          eeprom_pkg::PH_ADDR2: begin
            phase_q <= is_rd_q ? eeprom_pkg::PH_READ
                               : eeprom_pkg::PH_WDATA;
          end
          eeprom_pkg::PH_SDATA: phase_q <= eeprom_pkg::PH_IDLE;
          default: phase_q <= phase_q;
        endcase
      end
    end
  end

  // frame summary, kept past deselect for the system side
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      kind_q    <= eeprom_pkg::FK_NONE;
      exact_q   <= 1'b0;
      sr_byte_q <= 8'h00;
      addr_q    <= 15'h0000;
      ptr_q     <= 6'h00;
      pmask_q   <= '0;
    end else if (hold_n) begin
      exact_q <= (bit_cnt_q == `BIT_LAST);
      if (phase_q == eeprom_pkg::PH_OPCODE && bit_cnt_q == 3'h0) begin
        kind_q <= eeprom_pkg::FK_NONE;
      end
      if (byte_done) begin
        case (phase_q)
          eeprom_pkg::PH_OPCODE: begin
            if (!busy_l && rx_byte == `OPC_SET_WE) begin
              kind_q <= eeprom_pkg::FK_SET_WE;
            end else if (!busy_l && rx_byte == `OPC_CLR_WE) begin
              kind_q <= eeprom_pkg::FK_CLR_WE;
            end else if (!busy_l && rx_byte == `OPC_WRITE) begin
              pmask_q <= '0;
            end
          end
          eeprom_pkg::PH_ADDR1: addr_q[14:8] <= rx_byte[6:0];
          eeprom_pkg::PH_ADDR2: begin
            addr_q[7:0] <= rx_byte;
            ptr_q <= idsel_l ? {1'b0, rx_byte[4:0]} : rx_byte[5:0];
            if (is_rd_q) begin
              kind_q <= eeprom_pkg::FK_READ;
            end
          end
          eeprom_pkg::PH_WDATA: begin
            pmask_q[ptr_q] <= 1'b1;
            ptr_q  <= next_ptr(ptr_q, idsel_l);
            kind_q <= eeprom_pkg::FK_WRITE;
          end
          eeprom_pkg::PH_SDATA: begin
            sr_byte_q <= rx_byte;
            kind_q    <= eeprom_pkg::FK_SR_WR;
          end
          eeprom_pkg::PH_READ: begin
            addr_q <= idsel_l ? {addr_q[14:5], 5'(addr_q[4:0] + 5'h01)}
                              : mask_addr(15'(addr_q + 15'h0001));
          end
          default: kind_q <= kind_q;
        endcase
      end
    end
  end

  // page load buffer
  always_ff @(posedge sck) begin
    if (byte_done && phase_q == eeprom_pkg::PH_WDATA) begin
      pbuf_q[ptr_q] <= rx_byte;
    end
  end

  // byte to send: status, id page or array
  always_comb begin
    if (phase_q == eeprom_pkg::PH_STAT) begin
      rd_byte = sr_s2_q;
    end else if (idsel_l) begin
      rd_byte = id_q[addr_q[4:0]];
    end else begin
      rd_byte = mem_q[mask_addr(addr_q)];
    end
  end

  // output shifter, changes on falling sck
  always_ff @(negedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      so_q  <= 1'b0;
      osh_q <= 8'h00;
    end else if (hold_n) begin
      if (bit_cnt_q == 3'h0) begin
        so_q  <= rd_byte[7];
        osh_q <= {rd_byte[6:0], 1'b0};
      end else begin
        so_q  <= osh_q[7];
        osh_q <= {osh_q[6:0], 1'b0};
      end
    end
  end

  // output enable only while a read or status read streams
  always_ff @(negedge sck or negedge oe_rst_n) begin
    if (!oe_rst_n) begin
      so_oe_q <= 1'b0;
    end else begin
      so_oe_q <= (phase_q == eeprom_pkg::PH_READ) ||
                 (phase_q == eeprom_pkg::PH_STAT);
    end
  end

  assign so    = so_q;
  assign so_oe = so_oe_q;

  // --------------------------------------------------------------------
  // system side: end of frame, status register, programming
  // --------------------------------------------------------------------
  logic                  cs_s1_q, cs_s2_q, cs_s3_q;
  logic                  wp_s1_q, wp_s2_q, wp_s3_q;
  logic                  cs_rise, frame_end, abort_q;
  eeprom_pkg::wstate_t   state_q;
  logic [`TMR_W-1:0]     tmr_q;
  logic                  wel_q, protect_pin_enable_q, ipl_q, lip_q, cyc_data_q;
  logic [1:0]            bp_q;
  logic                  sr_ok, start_sr, start_arr, start_id;
  logic [14:0]           wr_addr;

  // pin synchronisers; third stage only for edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {cs_s1_q, cs_s2_q, cs_s3_q} <= 3'h7;
      {wp_s1_q, wp_s2_q, wp_s3_q} <= 3'h7;
    end else begin
      {cs_s1_q, cs_s2_q, cs_s3_q} <= {cs_n, cs_s1_q, cs_s2_q};
      {wp_s1_q, wp_s2_q, wp_s3_q} <= {wp_n, wp_s1_q, wp_s2_q};
    end
  end

  assign cs_rise   = cs_s2_q & ~cs_s3_q;
  assign frame_end = cs_rise && (state_q == eeprom_pkg::WS_IDLE);
  assign wr_addr   = mask_addr(addr_q);

  // enabled protect pin falling inside a selection spoils a status write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      abort_q <= 1'b0;
    end else if (protect_pin_enable_q && wp_s3_q && !wp_s2_q && !cs_s2_q) begin
      abort_q <= 1'b1;
    end else if (!cs_s2_q && cs_s3_q) begin
      abort_q <= 1'b0;
    end
  end

  // which write, if any, the finished frame may start
  always_comb begin
    sr_ok     = wel_q && !(protect_pin_enable_q && !wp_s2_q) && !abort_q;
    start_sr  = frame_end && exact_q && sr_ok &&
                (kind_q == eeprom_pkg::FK_SR_WR);
    start_arr = frame_end && exact_q && wel_q && !ipl_q &&
                (kind_q == eeprom_pkg::FK_WRITE) &&
                !prot_hit(wr_addr, bp_q);
    start_id  = frame_end && exact_q && wel_q && ipl_q && !lip_q &&
                (kind_q == eeprom_pkg::FK_WRITE) &&
                (bp_q != `BP_ALL) &&
                !prot_hit({10'h000, addr_q[4:0]}, bp_q);
  end

  // status bits and the self-timed write cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= eeprom_pkg::WS_IDLE;
      tmr_q      <= '0;
      wel_q      <= 1'(`SR_RESET >> `SR_WEL);
      bp_q       <= 2'b00;
      protect_pin_enable_q     <= 1'b0;
      ipl_q      <= 1'b0;
      lip_q      <= 1'b0;
      cyc_data_q <= 1'b0;
    end else begin
      case (state_q)
        eeprom_pkg::WS_IDLE: begin
          if (frame_end && exact_q && kind_q == eeprom_pkg::FK_SET_WE) begin
            wel_q <= 1'b1;
          end else if (frame_end && kind_q == eeprom_pkg::FK_CLR_WE) begin
            wel_q <= 1'b0;
          end
          if (frame_end && kind_q == eeprom_pkg::FK_READ) begin
            ipl_q <= 1'b0;
          end
          if (start_sr) begin
            bp_q   <= sr_byte_q[`SR_BP_HI:`SR_BP_LO];
            protect_pin_enable_q <= sr_byte_q[`SR_PEN];
            if (!(sr_byte_q[`SR_IDSEL] && sr_byte_q[`SR_LOCK])) begin
              ipl_q <= sr_byte_q[`SR_IDSEL];
              lip_q <= lip_q | sr_byte_q[`SR_LOCK];
            end
          end
          if (start_sr || start_arr || start_id) begin
            state_q    <= eeprom_pkg::WS_PROG;
            tmr_q      <= `TMR_W'(WRITE_CYCLE_CLKS - 1);
            cyc_data_q <= !start_sr;
          end
        end
        default: begin
          if (tmr_q == '0) begin
            state_q <= eeprom_pkg::WS_IDLE;
            wel_q   <= 1'b0;
            if (cyc_data_q) begin
              ipl_q <= 1'b0;
            end
          end else begin
            tmr_q <= `TMR_W'(tmr_q - 1'b1);
          end
        end
      endcase
    end
  end

  // loaded page bytes land in the array or id page at cycle start
  always_ff @(posedge clk) begin
    for (int i = 0; i < `PAGE_BYTES; i++) begin
      if (start_arr && pmask_q[i]) begin
        mem_q[{wr_addr[14:6], 6'(i)}] <= pbuf_q[i];
      end
    end
    for (int i = 0; i < `ID_BYTES; i++) begin
      if (start_id && pmask_q[i]) begin
        id_q[i] <= pbuf_q[i];
      end
    end
  end

  // status image as the host reads it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= `SR_RESET;
    end else begin
      status_q <= {protect_pin_enable_q, ipl_q, 1'b0, lip_q, bp_q, wel_q,
                   state_q == eeprom_pkg::WS_PROG};
    end
  end

  assign status = status_q;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  wel_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(wel_q) |-> $past(frame_end && exact_q &&
      kind_q == eeprom_pkg::FK_SET_WE)) else $error("latch set badly");

  prog_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(state_q == eeprom_pkg::WS_PROG) |-> $past(cs_rise && wel_q))
    else $error("write cycle began without cs rise or latch");

  busy_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == eeprom_pkg::WS_PROG) |=> status_q[`SR_BUSY])
    else $error("busy bit low during write cycle");

  wel_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(state_q == eeprom_pkg::WS_PROG) |-> !wel_q ##1 !status_q[1])
    else $error("latch not cleared after write cycle");

  prog_steady_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == eeprom_pkg::WS_PROG && tmr_q != '0) |=>
      (state_q == eeprom_pkg::WS_PROG) && $stable(bp_q) && $stable(protect_pin_enable_q))
    else $error("write cycle disturbed");

  pin_guard_a: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(bp_q) |-> $past(wel_q && !(protect_pin_enable_q && !wp_s2_q) && !abort_q))
    else $error("status changed while protected");

  lock_pair_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(ipl_q) |-> !$rose(lip_q))
    else $error("id select and lock set together");

  wp_abort_a: assert property (@(posedge clk) disable iff (!rst_n)
    (protect_pin_enable_q && wp_s3_q && !wp_s2_q && !cs_s2_q) |=> abort_q ##1 !start_sr)
    else $error("protect pin fall did not abort");

  ptr_wrap_a: assert property (@(posedge sck) disable iff (!frame_rst_n)
    (byte_done && phase_q == eeprom_pkg::PH_WDATA && !idsel_l &&
     ptr_q == 6'h3f) |=> ptr_q == 6'h00)
    else $error("page pointer did not wrap");

  bad_op_a: assert property (@(posedge sck) disable iff (!frame_rst_n)
    (phase_q == eeprom_pkg::PH_IDLE) |=> !so_oe_q)
    else $error("serial out driven after ignored opcode");

endmodule

// ==== bench/spi_host_model.sv ====
// host spi controller model, mode 0, sck period 12 ns only inside frames.
// assumes the bench fills txb and reads rxb around each xfer call.
`timescale 1ns/1ps

module spi_host_model (
  output logic      sck,    // serial clock, idles low
  output logic      cs_n,   // chip select
  output logic      si,     // serial data to device
  output logic      hold_n, // pause request
  input  wire logic so,     // serial data from device
  input  wire logic so_oe   // device drives so
);
  logic [7:0] txb [0:69];
  logic [7:0] rxb [0:69];
  int         hold_bit   = -1;
  logic       hold_float = 1'b0;
  logic       oe_any;

  // released line shows the inverse so nothing passes by chance
  wire so_line = so_oe ? so : ~so;

  initial begin
    {sck, cs_n, si, hold_n} = 4'b0101;
  end

  // one selection: nbits clocks msb first, then cs rises 10 ns after the last clock
  task automatic xfer(input int nbits);
    oe_any = 1'b0;
    cs_n = 1'b0;
    #20;
    for (int i = 0; i < nbits; i++) begin
      si = txb[i/8][7-i%8];
      #6 sck = 1'b1;
      rxb[i/8][7-i%8] = so_line;
      oe_any = oe_any | so_oe;
      #6 sck = 1'b0;
      if (i == hold_bit) begin
        #3 hold_n = 1'b0;
        #20 hold_float = !so_oe;
        hold_n = 1'b1;
        #3;
      end
    end
    #10 cs_n = 1'b1;
    si = ~si;
    #300;
  endtask
endmodule

// ==== bench/test_spi_eeprom_command_engine.sv ====
// self-checking bench for the serial eeprom command engine.
// assumes the host model in spi_host_model.sv and a 20-clk write cycle.
`timescale 1ns/1ps

module test_spi_eeprom_command_engine;
  logic       clk   = 1'b0;
  logic       rst_n = 1'b0;
  logic       wp_n  = 1'b1;
  wire        sck, cs_n, si, hold_n, so, so_oe;
  wire  [7:0] status;
  int         n_fail = 0;
  int         samples_checked = 0;

  always #25 clk = ~clk;

  spi_eeprom_command_engine #(.WRITE_CYCLE_CLKS(20))
    spi_eeprom_command_engine_inst (
    .clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si),
    .wp_n(wp_n), .hold_n(hold_n), .so(so), .so_oe(so_oe),
    .status(status));
  spi_host_model spi_host_model_inst (
    .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so),
    .so_oe(so_oe));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task test_done;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task ck(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task put(input int i, input logic [7:0] b);
    spi_host_model_inst.txb[i] = b;
  endtask
  task op(input logic [7:0] c, input int nb);
    put(0, c);
    spi_host_model_inst.xfer(nb);
  endtask
  function logic [7:0] rx(input int i);
    return spi_host_model_inst.rxb[i];
  endfunction
  task adr(input logic [15:0] a);
    put(1, a[15:8]);
    put(2, a[7:0]);
  endtask
  task sr_wr(input logic [7:0] v);
    put(1, v);
    op(8'h01, 16);
    ck(30);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    ck(4);
    rst_n = 1'b1;
    ck(3);
    chk(status, 8'h00);
    adr(16'h0010);
    put(3, 8'h5a);
    op(8'h02, 32);
    chk(status, 8'h00);
    op(8'h06, 9);
    chk(status, 8'h00);
    op(8'h06, 8);
    chk(status, 8'h02);
    op(8'h04, 8);
    chk(status, 8'h00);
    // two bytes from the last slot of a page: second lands on slot 0
    op(8'h06, 8);
    adr(16'hffff);
    put(3, 8'ha5);
    put(4, 8'h3c);
    op(8'h02, 40);
    chk(status, 8'h03);
    op(8'h05, 16);
    chk(rx(1), 8'h03);
    ck(30);
    chk(status, 8'h00);
    op(8'h06, 8);
    adr(16'h0000);
    put(3, 8'h77);
    op(8'h02, 32);
    ck(30);
    adr(16'h7fff);
    op(8'h03, 40);
    chk(rx(3), 8'ha5);
    chk(rx(4), 8'h77);
    adr(16'h7fc0);
    op(8'h03, 32);
    chk(rx(3), 8'h3c);
    // status write with id select and lock both set, full protect
    op(8'h06, 8);
    sr_wr(8'hff);
    chk(status, 8'h8c);
    op(8'h06, 8);
    adr(16'h0010);
    op(8'h02, 32);
    chk(status, 8'h8e);
    wp_n = 1'b0;
    ck(3);
    sr_wr(8'h00);
    chk(status, 8'h8e);
    // protect pin pulses low inside a status write frame only
    wp_n = 1'b1;
    ck(3);
    put(1, 8'h00);
    fork
      op(8'h01, 16);
      begin
        ck(2);
        wp_n = 1'b0;
        ck(2);
        wp_n = 1'b1;
      end
    join
    ck(30);
    chk(status, 8'h8e);
    sr_wr(8'h00);
    chk(status, 8'h00);
    // pin enable clear: a low protect pin no longer blocks
    wp_n = 1'b0;
    ck(3);
    op(8'h06, 8);
    sr_wr(8'h40);
    chk(status, 8'h40);
    wp_n = 1'b1;
    // id page write and read back through the five low bits
    op(8'h06, 8);
    adr(16'hffe3);
    put(3, 8'h66);
    op(8'h02, 32);
    ck(30);
    chk(status, 8'h00);
    op(8'h06, 8);
    sr_wr(8'h40);
    adr(16'h0003);
    op(8'h03, 32);
    chk(rx(3), 8'h66);
    chk(status, 8'h00);
    // trailing partial byte, unknown opcode, pause during status read
    op(8'h06, 8);
    adr(16'h0100);
    op(8'h02, 36);
    chk(status, 8'h02);
    op(8'hff, 24);
    chk({7'h00, spi_host_model_inst.oe_any}, 8'h00);
    spi_host_model_inst.hold_bit = 11;
    op(8'h05, 24);
    chk({7'h00, spi_host_model_inst.hold_float}, 8'h01);
    chk(rx(2), 8'h02);
    spi_host_model_inst.hold_bit = -1;
    // quarter and half protect: boundary refused, byte below taken
    sr_wr(8'h04);
    op(8'h06, 8);
    adr(16'h6000);
    op(8'h02, 32);
    chk(status, 8'h06);
    adr(16'h5fff);
    op(8'h02, 32);
    chk(status, 8'h07);
    op(8'h04, 8);
    chk(status, 8'h07);
    ck(30);
    op(8'h06, 8);
    sr_wr(8'h08);
    op(8'h06, 8);
    adr(16'h2000);
    op(8'h02, 32);
    chk(status, 8'h0a);
    adr(16'h1fff);
    op(8'h02, 32);
    chk(status, 8'h0b);
    ck(30);
    chk(status, 8'h08);
    test_done;
  end

  // watchdog well beyond the expected run of about 45 us
  initial begin
    #2000000;
    n_fail++;
    test_done;
  end
endmodule
